// ---- src/pin_electronics_mode_decode.sv ----
// Mode decode for a dual-channel pin electronics block with APB registers.
// Assumes pin and analog comparator inputs are asynchronous to CLK.
//
// Overview of operation
// RQ1: Normal mode: window outputs follow each channel's own threshold comparisons.
// RQ2: Differential mode: channel 0 window uses pin difference; channel 1 unchanged.
// RQ3: Load leaks when disabled, on when forced, else receive and termination decide.
// RQ4: Parametric unit disabled holds both go/no-go outputs low.
// RQ5: Enabled unit: go/no-go follows internal measured value against thresholds.
// RQ6: Amplifier measures voltage when select is 0, current when 1.
// RQ7: Measure pin is high impedance whenever measure enable is 0.
// RQ8: Source select 1 routes temperature node on channel 0, its ground on 1.
// RQ9: Source select 0: voltage if unit disabled, else voltage or current.
// RQ10: Receive high, not forced: termination select picks high-Z or termination level.
// RQ11: Decode follows control bits and receive level with no handshake.
`timescale 1ns/10ps
`default_nettype none

module pin_electronics_mode_decode (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Tester pattern inputs
    input wire logic [1:0] RECEIVE_WINDOW_IN,
    input wire logic [1:0] DRIVE_DATA_IN,
    // Analog comparator results
    input wire logic [1:0] DUT_ABOVE_HI,
    input wire logic [1:0] DUT_ABOVE_LO,
    input wire logic DIFF_ABOVE_HI,
    input wire logic DIFF_ABOVE_LO,
    input wire logic [1:0] MV_ABOVE_HI,
    input wire logic [1:0] MV_ABOVE_LO,
    input wire logic [1:0] MI_ABOVE_HI,
    input wire logic [1:0] MI_ABOVE_LO,
    // Decoded outputs
    output logic [1:0] WINDOW_HI_OUT,
    output logic [1:0] WINDOW_LO_OUT,
    output logic [1:0] PARAM_HI_GONOGO_OUT,
    output logic [1:0] PARAM_LO_GONOGO_OUT,
    output logic [1:0] ANALOG_MEASURE_PIN_OE_N,
    output pe_mode_pkg::ch_state_t [1:0] CH_STATE
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // One control bit of one channel
    function automatic logic fld(input logic [31:0] word, input int ch, input int pos);
        return word[ch * pe_mode_pkg::CH_STRIDE + pos];
    endfunction : fld

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    pe_mode_pkg::pins_t pins_in, s1_q, s2_q;

    assign pins_in = '{RECEIVE_WINDOW_IN, DRIVE_DATA_IN, DUT_ABOVE_HI, DUT_ABOVE_LO, DIFF_ABOVE_HI,
                       DIFF_ABOVE_LO, MV_ABOVE_HI, MV_ABOVE_LO, MI_ABOVE_HI, MI_ABOVE_LO};

    // Two-stage sync of every pin input
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    logic [31:0] drive_q, cmp_q, load_q, param_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] status_w;
    logic [7:0] idx;
    logic access, done, mapped;

    assign idx = PADDR[9:2];
    assign access = PSEL & PENABLE;
    assign done = access & pready_q;
    assign mapped = (PADDR[1:0] == 2'h0) &&
                    (idx == pe_mode_pkg::DRIVE_CTRL_IDX || idx == pe_mode_pkg::CMP_CTRL_IDX ||
                     idx == pe_mode_pkg::LOAD_CTRL_IDX || idx == pe_mode_pkg::PARAM_CTRL_IDX ||
                     idx == pe_mode_pkg::STATUS_IDX);

    // One wait state, then answer with data and error flag
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            if (access && !pready_q && !PWRITE) begin
                case (idx)
                    pe_mode_pkg::DRIVE_CTRL_IDX: prdata_q <= drive_q;
                    pe_mode_pkg::CMP_CTRL_IDX: prdata_q <= cmp_q;
                    pe_mode_pkg::LOAD_CTRL_IDX: prdata_q <= load_q;
                    pe_mode_pkg::PARAM_CTRL_IDX: prdata_q <= param_q;
                    pe_mode_pkg::STATUS_IDX: prdata_q <= status_w;
                    default: prdata_q <= 32'h00000000;
                endcase
                if (PADDR[1:0] != 2'h0) begin
                    prdata_q <= 32'h00000000;
                end
            end
        end
    end

    // Control registers, written at the completing edge
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            drive_q <= pe_mode_pkg::DRIVE_RST;
            cmp_q <= pe_mode_pkg::CMP_RST;
            load_q <= pe_mode_pkg::LOAD_RST;
            param_q <= pe_mode_pkg::PARAM_RST;
        end else if (done && PWRITE && PADDR[1:0] == 2'h0) begin
            case (idx)
                pe_mode_pkg::DRIVE_CTRL_IDX: drive_q <= PWDATA & pe_mode_pkg::DRIVE_MASK;
                pe_mode_pkg::CMP_CTRL_IDX: cmp_q <= PWDATA & pe_mode_pkg::CMP_MASK;
                pe_mode_pkg::LOAD_CTRL_IDX: load_q <= PWDATA & pe_mode_pkg::LOAD_MASK;
                pe_mode_pkg::PARAM_CTRL_IDX: param_q <= PWDATA & pe_mode_pkg::PARAM_MASK;
                default: ;
            endcase
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    pe_mode_pkg::ch_state_t [1:0] st_d;
    logic [1:0] win_hi_d, win_lo_d, pu_hi_d, pu_lo_d;

    // Purely combinational from control bits and synced pins
    always_comb begin // see RQ11
        for (int ch = 0; ch < 2; ch++) begin
            // Window comparators; channel 0 may switch to difference
            if (ch == 0 && cmp_q[pe_mode_pkg::DIFF_ON_BIT]) begin // see RQ2
                win_hi_d[ch] = s2_q.diff_above_hi;
                win_lo_d[ch] = s2_q.diff_above_lo;
            end else begin // see RQ1
                win_hi_d[ch] = s2_q.dut_above_hi[ch];
                win_lo_d[ch] = s2_q.dut_above_lo[ch];
            end
            // Driver state
            if (!fld(drive_q, ch, pe_mode_pkg::DRV_EN_BIT)) begin
                st_d[ch].drv = pe_mode_pkg::DRV_LEAK;
            end else if (fld(drive_q, ch, pe_mode_pkg::DRV_FORCE_BIT)) begin
                case ({fld(drive_q, ch, pe_mode_pkg::DRV_FSTATE_LSB + 1), fld(drive_q, ch, pe_mode_pkg::DRV_FSTATE_LSB)})
                    2'h0: st_d[ch].drv = pe_mode_pkg::DRV_VIL;
                    2'h1: st_d[ch].drv = pe_mode_pkg::DRV_VIH;
                    2'h2: st_d[ch].drv = pe_mode_pkg::DRV_HIZ;
                    default: st_d[ch].drv = pe_mode_pkg::DRV_VIT;
                endcase
            end else if (s2_q.receive_window_in[ch]) begin // see RQ10
                st_d[ch].drv = fld(drive_q, ch, pe_mode_pkg::TERM_SEL_BIT) ? pe_mode_pkg::DRV_VIT
                                                                           : pe_mode_pkg::DRV_HIZ;
            end else begin
                st_d[ch].drv = s2_q.drive_data_in[ch] ? pe_mode_pkg::DRV_VIH : pe_mode_pkg::DRV_VIL;
            end
            // Active load state
            if (!fld(load_q, ch, pe_mode_pkg::LOAD_EN_BIT)) begin // see RQ3
                st_d[ch].load = pe_mode_pkg::LD_LEAK;
            end else if (fld(load_q, ch, pe_mode_pkg::LOAD_FORCE_BIT)) begin
                st_d[ch].load = pe_mode_pkg::LD_ON;
            end else if (!s2_q.receive_window_in[ch]) begin
                st_d[ch].load = pe_mode_pkg::LD_OFF;
            end else begin
                st_d[ch].load = fld(drive_q, ch, pe_mode_pkg::TERM_SEL_BIT) ? pe_mode_pkg::LD_OFF
                                                                            : pe_mode_pkg::LD_ON;
            end
            // Go/no-go on internal amplifier, voltage or current
            if (!fld(param_q, ch, pe_mode_pkg::PU_ON_BIT)) begin // see RQ4
                pu_hi_d[ch] = 1'b0;
                pu_lo_d[ch] = 1'b0;
            end else if (fld(param_q, ch, pe_mode_pkg::VI_SEL_BIT)) begin // see RQ5, see RQ6
                pu_hi_d[ch] = s2_q.mi_above_hi[ch];
                pu_lo_d[ch] = s2_q.mi_above_lo[ch];
            end else begin // see RQ5, see RQ6
                pu_hi_d[ch] = s2_q.mv_above_hi[ch];
                pu_lo_d[ch] = s2_q.mv_above_lo[ch];
            end
            // Measure pin source
            if (!fld(param_q, ch, pe_mode_pkg::MEAS_ON_BIT)) begin // see RQ7
                st_d[ch].meas = pe_mode_pkg::MS_HIZ;
            end else if (fld(param_q, ch, pe_mode_pkg::MEAS_SEL_BIT)) begin // see RQ8
                st_d[ch].meas = (ch == 0) ? pe_mode_pkg::MS_TEMP_NODE : pe_mode_pkg::MS_TEMP_GND;
            end else if (!fld(param_q, ch, pe_mode_pkg::PU_ON_BIT)) begin // see RQ9
                st_d[ch].meas = pe_mode_pkg::MS_VOLT;
            end else begin // see RQ9
                st_d[ch].meas = fld(param_q, ch, pe_mode_pkg::VI_SEL_BIT) ? pe_mode_pkg::MS_AMP
                                                                          : pe_mode_pkg::MS_VOLT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    logic [1:0] win_hi_q, win_lo_q, pu_hi_q, pu_lo_q, oe_n_q;
    pe_mode_pkg::ch_state_t [1:0] st_q;

    // Register every decoded output
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            win_hi_q <= 2'h0;
            win_lo_q <= 2'h0;
            pu_hi_q <= 2'h0;
            pu_lo_q <= 2'h0;
            oe_n_q <= 2'h3;
            st_q <= '0;
        end else begin
            win_hi_q <= win_hi_d;
            win_lo_q <= win_lo_d;
            pu_hi_q <= pu_hi_d;
            pu_lo_q <= pu_lo_d;
            oe_n_q[0] <= (st_d[0].meas == pe_mode_pkg::MS_HIZ); // see RQ7
            oe_n_q[1] <= (st_d[1].meas == pe_mode_pkg::MS_HIZ); // see RQ7
            st_q <= st_d;
        end
    end

    assign WINDOW_HI_OUT = win_hi_q;
    assign WINDOW_LO_OUT = win_lo_q;
    assign PARAM_HI_GONOGO_OUT = pu_hi_q;
    assign PARAM_LO_GONOGO_OUT = pu_lo_q;
    assign ANALOG_MEASURE_PIN_OE_N = oe_n_q;
    assign CH_STATE = st_q;
    // Status word: states, then window and go/no-go bits
    assign status_w = {8'h00, pu_lo_q, pu_hi_q, win_lo_q, win_hi_q, st_q};

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_win_normal;
        !cmp_q[0] |=> WINDOW_HI_OUT[0] == $past(s2_q.dut_above_hi[0]) && WINDOW_LO_OUT[0] == $past(s2_q.dut_above_lo[0]);
    endproperty
    a_win_normal: assert property (p_win_normal) else $error("window ch0 wrong in normal mode"); // see RQ1
    property p_win_diff;
        cmp_q[0] |=> WINDOW_HI_OUT == {$past(s2_q.dut_above_hi[1]), $past(s2_q.diff_above_hi)};
    endproperty
    a_win_diff: assert property (p_win_diff) else $error("window wrong in differential mode"); // see RQ2
    property p_load_leak;
        !load_q[16] ##1 !load_q[16] |=> CH_STATE[1].load == pe_mode_pkg::LD_LEAK;
    endproperty
    a_load_leak: assert property (p_load_leak) else $error("load not in low leakage"); // see RQ3
    property p_pu_off;
        !param_q[0] |=> PARAM_HI_GONOGO_OUT[0] == 1'b0 && PARAM_LO_GONOGO_OUT[0] == 1'b0;
    endproperty
    a_pu_off: assert property (p_pu_off) else $error("go/no-go not held low"); // see RQ4
    property p_pu_current;
        param_q[16] && param_q[22] |=> PARAM_HI_GONOGO_OUT[1] == $past(s2_q.mi_above_hi[1]);
    endproperty
    a_pu_current: assert property (p_pu_current) else $error("go/no-go not on current"); // see RQ5 see RQ6
    property p_meas_hiz;
        !param_q[13] |=> ANALOG_MEASURE_PIN_OE_N[0] && CH_STATE[0].meas == pe_mode_pkg::MS_HIZ;
    endproperty
    a_meas_hiz: assert property (p_meas_hiz) else $error("measure pin not high impedance"); // see RQ7
    property p_meas_temp;
        param_q[29] && param_q[30] |=> !ANALOG_MEASURE_PIN_OE_N[1] && CH_STATE[1].meas == pe_mode_pkg::MS_TEMP_GND;
    endproperty
    a_meas_temp: assert property (p_meas_temp) else $error("temperature ground not routed"); // see RQ8
    property p_meas_volt;
        param_q[13] && !param_q[14] && !param_q[0] |=> CH_STATE[0].meas == pe_mode_pkg::MS_VOLT;
    endproperty
    a_meas_volt: assert property (p_meas_volt) else $error("measure pin not on voltage"); // see RQ9
    property p_drv_term;
        drive_q[1:0] == 2'h1 && drive_q[4] && s2_q.receive_window_in[0] |=> CH_STATE[0].drv == pe_mode_pkg::DRV_VIT;
    endproperty
    a_drv_term: assert property (p_drv_term) else $error("driver not at termination level"); // see RQ10

endmodule : pin_electronics_mode_decode

`default_nettype wire

// ---- src/pe_mode_pkg.sv ----
// Constants, types and register layout for the pin electronics mode decode.
// Assumes an APB master with 32-bit data and word-aligned register access.
package pe_mode_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] DRIVE_CTRL_IDX = 8'h19;
    localparam logic [7:0] CMP_CTRL_IDX = 8'h1A;
    localparam logic [7:0] LOAD_CTRL_IDX = 8'h1B;
    localparam logic [7:0] PARAM_CTRL_IDX = 8'h1C;
    localparam logic [7:0] STATUS_IDX = 8'h1D;

    // Channel 1 fields sit this many bits above channel 0
    localparam int CH_STRIDE = 16;

    // Field positions within one channel's half-word
    localparam int DRV_EN_BIT = 0;
    localparam int DRV_FORCE_BIT = 1;
    localparam int DRV_FSTATE_LSB = 2;
    localparam int TERM_SEL_BIT = 4;
    localparam int DIFF_ON_BIT = 0;
    localparam int LOAD_EN_BIT = 0;
    localparam int LOAD_FORCE_BIT = 1;
    localparam int PU_ON_BIT = 0;
    localparam int PU_IDLE_BIT = 1;
    localparam int VI_SEL_BIT = 6;
    localparam int MEAS_ON_BIT = 13;
    localparam int MEAS_SEL_BIT = 14;

    // Writable bits of each register
    localparam logic [31:0] DRIVE_MASK = 32'h001F001F;
    localparam logic [31:0] CMP_MASK = 32'h00000001;
    localparam logic [31:0] LOAD_MASK = 32'h00030003;
    localparam logic [31:0] PARAM_MASK = 32'h60436043;

    // Reset values
    localparam logic [31:0] DRIVE_RST = 32'h00000000;
    localparam logic [31:0] CMP_RST = 32'h00000000;
    localparam logic [31:0] LOAD_RST = 32'h00000000;
    localparam logic [31:0] PARAM_RST = 32'h00000000;

    typedef enum logic [2:0] {DRV_LEAK, DRV_VIL, DRV_VIH, DRV_HIZ, DRV_VIT} drv_state_t;
    typedef enum logic [1:0] {LD_LEAK, LD_ON, LD_OFF} load_state_t;
    typedef enum logic [2:0] {MS_HIZ, MS_VOLT, MS_AMP, MS_TEMP_NODE, MS_TEMP_GND} meas_src_t;

    // Decoded state of one channel, 8 bits
    typedef struct packed {
        meas_src_t meas;
        load_state_t load;
        drv_state_t drv;
    } ch_state_t;

    // Pin and analog comparator inputs, sampled together
    typedef struct packed {
        logic [1:0] receive_window_in;
        logic [1:0] drive_data_in;
        logic [1:0] dut_above_hi;
        logic [1:0] dut_above_lo;
        logic diff_above_hi;
        logic diff_above_lo;
        logic [1:0] mv_above_hi;
        logic [1:0] mv_above_lo;
        logic [1:0] mi_above_hi;
        logic [1:0] mi_above_lo;
    } pins_t;

endpackage : pe_mode_pkg

// ---- tb/tester_pattern_model.sv ----
// Tester pattern model: drives receive, data and analog compare levels.
// Assumes the bench hands it the wanted levels; they reach the pins one edge later.
`timescale 1ns/10ps
`default_nettype none

module tester_pattern_model (
    // Clock
    input wire logic CLK,
    // Wanted and driven levels
    input wire pe_mode_pkg::pins_t WANT,
    output var pe_mode_pkg::pins_t PINS
);
    // Quiet pins before the first edge, then launch levels just after each edge
    initial begin
        PINS = '0;
        forever begin
            @(posedge CLK);
            PINS <= WANT;
        end
    end
endmodule : tester_pattern_model

`default_nettype wire

// ---- tb/test_pin_electronics_mode_decode.sv ----
// Self-checking bench for the pin electronics mode decode.
// Assumes one 100 MHz clock, the APB slave and the tester model beside it.
`timescale 1ns/10ps
`default_nettype none

module test_pin_electronics_mode_decode;
    logic clk, rst_n, psel, penable, pwrite, snap, pready, pslverr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, lf;
    logic [1:0] whi, wlo, ghi, glo, oe;
    pe_mode_pkg::ch_state_t [1:0] st;
    pe_mode_pkg::pins_t want, pins;
    logic [32:0] rd_q[$];
    logic [25:0] out_q[$];
    logic [32:0] rd_e;
    logic [25:0] out_e, x;
    logic [31:0] rv[4];
    logic [31:0] mk[4];
    int bad_count, checks;

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    pin_electronics_mode_decode pin_electronics_mode_decode_inst (
        .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RECEIVE_WINDOW_IN(pins.receive_window_in), .DRIVE_DATA_IN(pins.drive_data_in),
        .DUT_ABOVE_HI(pins.dut_above_hi), .DUT_ABOVE_LO(pins.dut_above_lo),
        .DIFF_ABOVE_HI(pins.diff_above_hi), .DIFF_ABOVE_LO(pins.diff_above_lo),
        .MV_ABOVE_HI(pins.mv_above_hi), .MV_ABOVE_LO(pins.mv_above_lo),
        .MI_ABOVE_HI(pins.mi_above_hi), .MI_ABOVE_LO(pins.mi_above_lo),
        .WINDOW_HI_OUT(whi), .WINDOW_LO_OUT(wlo), .PARAM_HI_GONOGO_OUT(ghi),
        .PARAM_LO_GONOGO_OUT(glo), .ANALOG_MEASURE_PIN_OE_N(oe), .CH_STATE(st)
    );

    tester_pattern_model tester_pattern_model_inst (.CLK(clk), .WANT(want), .PINS(pins));

    ////////////////////////////////////////////////////////////////////////
    // Random source
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : next_rand

    // Expected outputs {oe, glo, ghi, wlo, whi, state} from registers and pins
    function automatic logic [25:0] expect_out(input pe_mode_pkg::pins_t p);
        logic [15:0] d, l, f, s;
        logic [1:0] wh, wl, gh, gl, o;
        logic r;
        for (int c = 0; c < 2; c++) begin
            d = rv[0][c*16 +: 16];
            l = rv[2][c*16 +: 16];
            f = rv[3][c*16 +: 16];
            r = p.receive_window_in[c];
            wh[c] = (c == 0 && rv[1][0]) ? p.diff_above_hi : p.dut_above_hi[c];
            wl[c] = (c == 0 && rv[1][0]) ? p.diff_above_lo : p.dut_above_lo[c];
            s[c*8 +: 3] = !d[0] ? 3'h0 : d[1] ? d[3:2] + 3'h1 : r ? (d[4] ? 3'h4 : 3'h3)
                : (p.drive_data_in[c] ? 3'h2 : 3'h1);
            s[c*8+3 +: 2] = !l[0] ? 2'h0 : l[1] ? 2'h1 : (r && !d[4]) ? 2'h1 : 2'h2;
            s[c*8+5 +: 3] = !f[13] ? 3'h0 : f[14] ? (c ? 3'h4 : 3'h3)
                : (f[0] && f[6]) ? 3'h2 : 3'h1;
            o[c] = !f[13];
            gh[c] = f[0] & (f[6] ? p.mi_above_hi[c] : p.mv_above_hi[c]);
            gl[c] = f[0] & (f[6] ? p.mi_above_lo[c] : p.mv_above_lo[c]);
        end
        return {o, gl, gh, wl, wh, s};
    endfunction : expect_out

    ////////////////////////////////////////////////////////////////////////
    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [32:0] e);
        rd_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Let pins and registers settle, then note and sample the outputs
    task automatic check_out();
        repeat (6) @(posedge clk);
        out_q.push_back(expect_out(want));
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
    endtask : check_out

    // Read the status word and all control registers back
    task automatic read_all();
        x = expect_out(want);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, {8'h19 + 8'(k), 2'h0}, 32'h0, {1'b0, rv[k]});
        end
        apb(1'b0, {8'h1D, 2'h0}, 32'h0, {9'h000, x[23:0]});
    endtask : read_all

    task automatic finish_test(input string name);
        $display("test %s ends", name);
    endtask : finish_test

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // Monitor: pops the oldest note whenever a result appears
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            rd_e = rd_q.pop_front();
            checks++;
            if ({pslverr, pwrite ? 32'h0 : prdata} !== rd_e) begin
                bad_count++;
                $display("[FAIL] %0t bus answer %h, expected %h", $time, {pslverr, prdata}, rd_e);
            end
        end
        if (snap) begin
            out_e = out_q.pop_front();
            checks++;
            if ({oe, glo, ghi, wlo, whi, st} !== out_e) begin
                bad_count++;
                $display("[FAIL] %0t outputs %h, expected %h", $time, {oe, glo, ghi, wlo, whi, st}, out_e);
            end
        end
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        $display("[FAIL] %0t run took too long", $time);
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, snap, paddr, pwdata} = '0;
        want = '0;
        lf = 32'h0000FBDB;
        mk = '{pe_mode_pkg::DRIVE_MASK, pe_mode_pkg::CMP_MASK, pe_mode_pkg::LOAD_MASK, pe_mode_pkg::PARAM_MASK};
        rv = '{default: 32'h0};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        read_all();
        check_out();
        finish_test("reset");
        // Every forced drive state on both channels
        for (int fs = 0; fs < 4; fs++) begin
            rv[0] = 32'h00030003 | (fs << 2) | (fs << 18);
            apb(1'b1, {8'h19, 2'h0}, rv[0], 33'h0);
            check_out();
        end
        finish_test("force");
        // Random registers and pins, then pins alone
        for (int i = 0; i < 60; i++) begin
            for (int k = 0; k < 4; k++) begin
                lf = next_rand(lf);
                rv[k] = lf & mk[k];
                apb(1'b1, {8'h19 + 8'(k), 2'h0}, lf, 33'h0);
            end
            lf = next_rand(lf);
            want <= pe_mode_pkg::pins_t'(lf[17:0]);
            check_out();
            lf = next_rand(lf);
            want <= pe_mode_pkg::pins_t'(lf[17:0]);
            check_out();
            read_all();
        end
        finish_test("random");
        // Refused and ignored accesses
        apb(1'b1, {8'hF0, 2'h0}, 32'hFFFFFFFF, {1'b1, 32'h0});
        apb(1'b0, {8'hF0, 2'h0}, 32'h0, {1'b1, 32'h0});
        apb(1'b1, {8'h19, 2'h1}, 32'hFFFFFFFF, {1'b1, 32'h0});
        apb(1'b0, {8'h1A, 2'h2}, 32'h0, {1'b1, 32'h0});
        apb(1'b1, {8'h1D, 2'h0}, 32'hFFFFFFFF, 33'h0);
        read_all();
        finish_test("errors");
        // Reset in mid-run: registers, states, go/no-go and OE return to reset values; windows follow pins
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rv = '{default: 32'h0};
        read_all();
        check_out();
        finish_test("reset again");
        give_verdict();
    end
endmodule : test_pin_electronics_mode_decode

`default_nettype wire
